//--- shared/tmr_pkg.sv
// Constants, register map and types for the two-timer block
package tmr_pkg;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 4;
	// Register addresses, one per 16-bit register
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_A_CNT = 4'h1;
	localparam logic [3:0] REG_B_CNT = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_MASK = 4'h4;
	localparam logic [3:0] REG_A_EVT = 4'h5;
	// Control field positions
	localparam int CTRL_A_START = 0;
	localparam int CTRL_A_MODE_LO = 1;
	localparam int CTRL_A_UP = 3;
	localparam int CTRL_A_FREE = 4;
	localparam int CTRL_B_START = 5;
	localparam int CTRL_B_MODE = 6;
	localparam int CTRL_A_PWM_LOW = 8;
	// Status bits
	localparam int ST_A_REQ = 0;
	localparam int ST_B_REQ = 1;
	// Reload read values and reset values
	localparam logic [15:0] RELOAD_UNDER = 16'hffff;
	localparam logic [15:0] RELOAD_OVER = 16'h0000;
	localparam logic [15:0] CNT_RESET = 16'hffff;
	localparam logic [1:0] STAT_RESET = 2'h0;
	localparam logic [1:0] MASK_RESET = 2'h0;
	// Divider for the count source
	localparam int PRESCALE = 2;
	typedef enum logic [1:0] {
		MODE_TIMER,
		MODE_EVENT,
		MODE_ONESHOT,
		MODE_PWM
	} a_mode_t;
endpackage : tmr_pkg

//--- design/tmr_chan_b.sv
`timescale 1ns/100ps
// Timer B counter channel: timer or event mode, down counting
module tmr_chan_b #(
	parameter int W = 16
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic evt,
	input wire logic event_mode,
	input wire logic run,
	input wire logic wr,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] value,
	output logic underflow
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic [W-1:0] reload;
		logic uf;
	} b_state_t;
	b_state_t s_q;
	b_state_t s_d;
	logic step;

	// Count source chosen by mode
	assign step = run & (event_mode ? evt : tick);

	// Live count; at reload the read shows all ones
	always_comb begin
		s_d = s_q;
		s_d.uf = 1'b0;
		if (wr) begin
			s_d.reload = wdata;
			if (!run) begin
				s_d.cnt = wdata;
			end
		end else if (step) begin
			if (s_q.cnt == '0) begin
				s_d.cnt = s_q.reload;
				s_d.uf = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s_q <= '{cnt: '1, reload: '1, uf: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign value = s_q.uf ? tmr_pkg::RELOAD_UNDER : s_q.cnt;
	assign underflow = s_q.uf;

	a_b_halt_write: assert property (@(posedge clock) disable iff (!rst_b)
		wr && !run |=> value == $past(wdata)) else $error("timer B halted write lost");
endmodule : tmr_chan_b

//--- design/tmr_core.sv
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
// Timer A with one-shot and PWM behaviour, timer B, registers and interrupt
module tmr_core #(
	parameter int W = 16
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic a_event_pin,
	input wire logic a_trigger_pin,
	input wire logic b_event_pin,
	output logic [15:0] rdata,
	output logic timer_a_pulse_output_pin,
	output logic irq
);
	typedef struct packed {
		logic [1:0] sa_ev;
		logic [1:0] sa_tr;
		logic [1:0] sb_ev;
		logic prev_ev;
		logic prev_tr;
		logic prev_bev;
		logic [3:0] div;
		logic a_start;
		tmr_pkg::a_mode_t a_mode;
		logic a_up;
		logic a_free;
		logic b_start;
		logic b_mode;
		logic [7:0] pwm_low;
		logic [W-1:0] a_cnt;
		logic [W-1:0] a_reload;
		logic a_rl_under;
		logic a_rl_over;
		logic a_fire;
		logic a_out;
		logic [W-1:0] pwm_ph;
		logic [1:0] stat;
		logic [1:0] mask;
		logic [15:0] rdata;
		logic irq;
	} core_state_t;
	core_state_t s_q;
	core_state_t s_d;
	logic tick;
	logic a_evt;
	logic a_trig;
	logic b_evt;
	logic [W-1:0] b_val;
	logic b_uf;
	logic wr_ctrl;
	tmr_pkg::a_mode_t new_mode;
	logic a_count_mode;
	logic a_event_sel;

	// Synchronised pin edges
	assign a_evt = s_q.sa_ev[1] & ~s_q.prev_ev;
	assign a_trig = s_q.sa_tr[1] & ~s_q.prev_tr;
	assign b_evt = s_q.sb_ev[1] & ~s_q.prev_bev;
	assign tick = (s_q.div == 4'(tmr_pkg::PRESCALE - 1));
	assign wr_ctrl = wr && addr == tmr_pkg::REG_CTRL;
	assign new_mode = tmr_pkg::a_mode_t'(wdata[tmr_pkg::CTRL_A_MODE_LO +: 2]);
	assign a_count_mode = s_q.a_mode == tmr_pkg::MODE_TIMER || s_q.a_mode == tmr_pkg::MODE_EVENT;
	assign a_event_sel = s_q.a_mode == tmr_pkg::MODE_EVENT;

	tmr_chan_b #(
		.W(W)
	) tmr_chan_b_i (
		.clock(clock),
		.rst_b(rst_b),
		.tick(tick),
		.evt(b_evt),
		.event_mode(s_q.b_mode),
		.run(s_q.b_start),
		.wr(wr && addr == tmr_pkg::REG_B_CNT),
		.wdata(wdata[W-1:0]),
		.value(b_val),
		.underflow(b_uf)
	);

	// Next state of the whole block
	always_comb begin
		s_d = s_q;
		s_d.sa_ev = {s_q.sa_ev[0], a_event_pin};
		s_d.sa_tr = {s_q.sa_tr[0], a_trigger_pin};
		s_d.sb_ev = {s_q.sb_ev[0], b_event_pin};
		s_d.prev_ev = s_q.sa_ev[1];
		s_d.prev_tr = s_q.sa_tr[1];
		s_d.prev_bev = s_q.sb_ev[1];
		s_d.div = tick ? 4'h0 : s_q.div + 4'h1;
		s_d.a_rl_under = 1'b0;
		s_d.a_rl_over = 1'b0;
		// Write one clears first, so a hardware set in the same cycle wins
		if (wr && addr == tmr_pkg::REG_STATUS) begin
			s_d.stat = s_q.stat & ~wdata[1:0];
		end
		if (b_uf) begin
			s_d.stat[tmr_pkg::ST_B_REQ] = 1'b1;
		end
		// Timer A counting
		if (s_q.a_start) begin
			unique case (s_q.a_mode)
				tmr_pkg::MODE_TIMER, tmr_pkg::MODE_EVENT: begin
					if (a_event_sel ? a_evt : tick) begin
						if (a_event_sel && s_q.a_up) begin
							if (s_q.a_cnt == '1) begin
								s_d.a_cnt = s_q.a_free ? '0 : s_q.a_reload;
								s_d.a_rl_over = 1'b1;
								s_d.stat[tmr_pkg::ST_A_REQ] = 1'b1;
							end else begin
								s_d.a_cnt = s_q.a_cnt + 1'b1;
							end
						end else if (s_q.a_cnt == '0) begin
							s_d.a_cnt = s_q.a_free && a_event_sel ? '1 : s_q.a_reload;
							s_d.a_rl_under = 1'b1;
							s_d.stat[tmr_pkg::ST_A_REQ] = 1'b1;
						end else begin
							s_d.a_cnt = s_q.a_cnt - 1'b1;
						end
					end
				end
				tmr_pkg::MODE_ONESHOT: begin
					if (a_trig && !s_q.a_fire) begin
						s_d.a_fire = 1'b1;
						s_d.a_out = 1'b1;
						s_d.a_cnt = s_q.a_reload;
					end else if (s_q.a_fire && tick) begin
						if (s_q.a_cnt == '0) begin
							s_d.a_fire = 1'b0;
							s_d.a_out = 1'b0;
							s_d.a_cnt = s_q.a_reload;
							s_d.stat[tmr_pkg::ST_A_REQ] = 1'b1;
						end else begin
							s_d.a_cnt = s_q.a_cnt - 1'b1;
						end
					end
				end
				tmr_pkg::MODE_PWM: begin
					// High phase uses the reload, low phase the separate width
					if (tick) begin
						if (s_q.pwm_ph == '0) begin
							s_d.a_out = ~s_q.a_out;
							s_d.pwm_ph = s_q.a_out ? W'(s_q.pwm_low) : s_q.a_reload;
							if (s_q.a_out) begin
								s_d.stat[tmr_pkg::ST_A_REQ] = 1'b1;
							end
						end else begin
							s_d.pwm_ph = s_q.pwm_ph - 1'b1;
						end
					end
				end
			endcase
		end
		// Register writes
		if (wr) begin
			unique case (addr)
				tmr_pkg::REG_CTRL: begin
					s_d.a_start = wdata[tmr_pkg::CTRL_A_START];
					s_d.a_mode = new_mode;
					s_d.a_up = wdata[tmr_pkg::CTRL_A_UP];
					s_d.a_free = wdata[tmr_pkg::CTRL_A_FREE];
					s_d.b_start = wdata[tmr_pkg::CTRL_B_START];
					s_d.b_mode = wdata[tmr_pkg::CTRL_B_MODE];
					s_d.pwm_low = wdata[tmr_pkg::CTRL_A_PWM_LOW +: 8];
					// Spurious request on entering one-shot or PWM from a counting mode
					if ((new_mode == tmr_pkg::MODE_ONESHOT || new_mode == tmr_pkg::MODE_PWM)
							&& a_count_mode) begin
						s_d.stat[tmr_pkg::ST_A_REQ] = 1'b1;
					end
					if (s_q.a_start && !wdata[tmr_pkg::CTRL_A_START]) begin
						if (s_q.a_mode == tmr_pkg::MODE_ONESHOT) begin
							// Also cancels a trigger caught in this same cycle
							s_d.a_fire = 1'b0;
							s_d.a_cnt = s_q.a_reload;
							s_d.a_out = 1'b0;
							if (s_q.a_fire) begin
								s_d.stat[tmr_pkg::ST_A_REQ] = 1'b1;
							end
						end else if (s_q.a_mode == tmr_pkg::MODE_PWM) begin
							// Pin ends low; a toggle due now must not lift it
							s_d.a_out = 1'b0;
							if (s_q.a_out) begin
								s_d.stat[tmr_pkg::ST_A_REQ] = 1'b1;
							end
						end
						s_d.pwm_ph = '0;
					end
				end
				tmr_pkg::REG_A_CNT: begin
					s_d.a_reload = wdata[W-1:0];
					if (!s_q.a_start) begin
						s_d.a_cnt = wdata[W-1:0];
					end
				end
				tmr_pkg::REG_STATUS: begin
					// Cleared ahead of the hardware sets above
				end
				tmr_pkg::REG_MASK: begin
					s_d.mask = wdata[1:0];
				end
				default: begin
				end
			endcase
		end
		// Read data one cycle later
		s_d.rdata = 16'h0000;
		if (rd) begin
			unique case (addr)
				tmr_pkg::REG_CTRL: begin
					s_d.rdata = {s_q.pwm_low, 1'b0, s_q.b_mode, s_q.b_start, s_q.a_free,
						s_q.a_up, s_q.a_mode, s_q.a_start};
				end
				tmr_pkg::REG_A_CNT: begin
					if (s_q.a_rl_under) begin
						s_d.rdata = tmr_pkg::RELOAD_UNDER;
					end else if (s_q.a_rl_over) begin
						s_d.rdata = tmr_pkg::RELOAD_OVER;
					end else begin
						s_d.rdata = s_q.a_cnt;
					end
				end
				tmr_pkg::REG_B_CNT: s_d.rdata = b_val;
				tmr_pkg::REG_STATUS: s_d.rdata = {14'h0000, s_q.stat};
				tmr_pkg::REG_MASK: s_d.rdata = {14'h0000, s_q.mask};
				tmr_pkg::REG_A_EVT: s_d.rdata = {13'h0000, s_q.a_fire, s_q.a_out, s_q.a_start};
				default: s_d.rdata = 16'h0000;
			endcase
		end
		s_d.irq = |(s_d.stat & s_d.mask);
	end

	// Single state register; reset values are constants only
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.a_cnt <= tmr_pkg::CNT_RESET;
			s_q.a_reload <= tmr_pkg::CNT_RESET;
			s_q.stat <= tmr_pkg::STAT_RESET;
			s_q.mask <= tmr_pkg::MASK_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign timer_a_pulse_output_pin = s_q.a_out;
	assign irq = s_q.irq;

	a_oneshot_abort: assert property (@(posedge clock) disable iff (!rst_b)
		wr_ctrl && !wdata[0] && s_q.a_start && s_q.a_fire && s_q.a_mode == tmr_pkg::MODE_ONESHOT
		|=> !timer_a_pulse_output_pin && s_q.stat[0] && s_q.a_cnt == $past(s_q.a_reload))
		else $error("one-shot abort wrong");
	a_pwm_low_stop: assert property (@(posedge clock) disable iff (!rst_b)
		wr_ctrl && !wdata[0] && s_q.a_start && !s_q.a_out && s_q.a_mode == tmr_pkg::MODE_PWM
		&& !s_q.stat[0] |=> !timer_a_pulse_output_pin && !s_q.stat[0])
		else $error("PWM low stop changed state");
	a_pwm_high_stop: assert property (@(posedge clock) disable iff (!rst_b)
		wr_ctrl && !wdata[0] && s_q.a_start && s_q.a_out && s_q.a_mode == tmr_pkg::MODE_PWM
		|=> !timer_a_pulse_output_pin && s_q.stat[0]) else $error("PWM high stop wrong");
	a_mode_req: assert property (@(posedge clock) disable iff (!rst_b)
		wr_ctrl && a_count_mode && new_mode == tmr_pkg::MODE_ONESHOT |=> s_q.stat[0])
		else $error("mode change request missing");
	a_read_live: assert property (@(posedge clock) disable iff (!rst_b)
		rd && addr == tmr_pkg::REG_A_CNT && !s_q.a_rl_under && !s_q.a_rl_over
		|=> rdata == $past(s_q.a_cnt)) else $error("live read wrong");
	a_read_reload: assert property (@(posedge clock) disable iff (!rst_b)
		rd && addr == tmr_pkg::REG_A_CNT && s_q.a_rl_under |=> rdata == 16'hffff)
		else $error("reload read wrong");
	a_halt_write: assert property (@(posedge clock) disable iff (!rst_b)
		wr && addr == tmr_pkg::REG_A_CNT && !s_q.a_start ##1 rd && addr == tmr_pkg::REG_A_CNT
		&& !s_q.a_start |=> rdata == $past(wdata, 2)) else $error("halted write read wrong");
	a_irq_level: assert property (@(posedge clock) disable iff (!rst_b)
		##1 irq == |$past(s_d.stat & s_d.mask)) else $error("irq mismatch");
endmodule : tmr_core

//--- bench/tmr_core_bench.sv
// Self-checking bench for the two-timer block
`timescale 1ns/100ps
module tmr_core_bench;
	localparam logic [3:0] ctl = tmr_pkg::REG_CTRL, acnt = tmr_pkg::REG_A_CNT;
	localparam logic [3:0] bcnt = tmr_pkg::REG_B_CNT, st = tmr_pkg::REG_STATUS;
	localparam logic [3:0] msk = tmr_pkg::REG_MASK, aev = tmr_pkg::REG_A_EVT;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic a_ev = 1'b0;
	logic a_trg = 1'b0;
	logic b_ev = 1'b0;
	logic [15:0] rdata;
	logic pin;
	logic irq;
	logic [15:0] v;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	int hits;
	int odd;

	// 200 MHz clock
	always #2.5 clock = ~clock;

	tmr_core #(.W(16)) tmr_core_i (
		.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.a_event_pin(a_ev), .a_trigger_pin(a_trg), .b_event_pin(b_ev),
		.rdata(rdata), .timer_a_pulse_output_pin(pin), .irq(irq)
	);

	// Closing report, the only place the run ends
	task automatic results;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	// Ceiling well above the few hundred cycles the tests need
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			results();
		end
	end

	task automatic cmp16(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : cmp16

	task automatic cmp1(input string n, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask : cmp1

	// One-cycle write strobe
	task automatic bw(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask : bw

	// Read data stand only in the cycle after the strobe
	task automatic rc(input logic [3:0] a, input logic [15:0] e, input string n);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		v = rdata;
		cmp16(n, e, v);
	endtask : rc

	// Write then read with no gap, as a halted rewrite is checked
	task automatic bw_rc(input logic [3:0] a, input logic [15:0] d, input string n);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		v = rdata;
		cmp16(n, d, v);
	endtask : bw_rc

	task automatic settle(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : settle

	// Back-to-back reads, since the reload value shows for one cycle only
	task automatic sweep(input logic [3:0] a, input logic [15:0] spot);
		hits = 0;
		odd = 0;
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		for (int i = 0; i < 24; i++) begin
			@(posedge clock);
			rd <= (i < 23);
			#1;
			if (rdata === spot) begin
				hits++;
			end else if (rdata !== 16'h0000 && rdata !== 16'h0001 && rdata !== 16'hffff) begin
				odd++;
			end
		end
		cmp1("reload_seen", 1'b1, hits > 0);
		cmp1("reload_odd", 1'b0, odd > 0);
	endtask : sweep

	// Bounded wait for an output level
	task automatic wait_pin(input logic lvl);
		int n;
		n = 0;
		while (pin !== lvl && n < 200) begin
			settle(1);
			n++;
		end
		cmp1("pin_level", lvl, pin);
	endtask : wait_pin

	initial begin
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		// Reset values and an unmapped place
		rc(acnt, tmr_pkg::CNT_RESET, "a_cnt_reset");
		rc(st, 16'h0000, "status_reset");
		rc(4'hf, 16'h0000, "unmapped");
		cmp1("pin_reset", 1'b0, pin);
		cmp1("irq_reset", 1'b0, irq);
		// Halted writes read back as written
		bw_rc(acnt, 16'h1234, "a_halted");
		bw_rc(bcnt, 16'h00a5, "b_halted");
		// Live count while running, both channels
		bw(acnt, 16'h0200);
		bw(bcnt, 16'h0200);
		bw(ctl, 16'h0021);
		settle(20);
		// Ten prescaled ticks for A, eleven for B by the time each is read
		rc(acnt, 16'h01f6, "a_live_read");
		cmp1("a_live", 1'b1, v < 16'h0200 && v > 16'h01e0);
		rc(bcnt, 16'h01f5, "b_live_read");
		cmp1("b_live", 1'b1, v < 16'h0200 && v > 16'h01e0);
		// Short reload so reads land on the reload instant
		bw(ctl, 16'h0000);
		bw(acnt, 16'h0001);
		bw(bcnt, 16'h0001);
		bw(ctl, 16'h0021);
		sweep(acnt, tmr_pkg::RELOAD_UNDER);
		sweep(bcnt, tmr_pkg::RELOAD_UNDER);
		// Event mode, underflow then overflow
		bw(ctl, 16'h0000);
		bw(acnt, 16'h0000);
		bw(ctl, 16'h0003);
		@(posedge clock);
		a_ev <= 1'b1;
		sweep(acnt, tmr_pkg::RELOAD_UNDER);
		@(posedge clock);
		a_ev <= 1'b0;
		bw(ctl, 16'h0000);
		bw(acnt, 16'hffff);
		bw(ctl, 16'h000b);
		@(posedge clock);
		a_ev <= 1'b1;
		sweep(acnt, tmr_pkg::RELOAD_OVER);
		bw(ctl, 16'h0000);
		bw(acnt, 16'h0000);
		bw(st, 16'h0003);
		rc(st, 16'h0000, "status_quiet");
		// Timer to one-shot raises a request; mask gates the line
		bw(ctl, 16'h0004);
		rc(st, 16'h0001, "oneshot_select");
		cmp1("irq_masked", 1'b0, irq);
		bw(msk, 16'h0001);
		settle(2);
		cmp1("irq_unmasked", 1'b1, irq);
		bw(st, 16'h0001);
		settle(2);
		rc(st, 16'h0000, "status_cleared");
		cmp1("irq_cleared", 1'b0, irq);
		// One-shot aborted mid-count
		bw(acnt, 16'h0100);
		bw(ctl, 16'h0005);
		@(posedge clock);
		a_trg <= 1'b1;
		settle(10);
		rc(aev, 16'h0007, "a_state_read");
		cmp1("a_firing", 1'b1, v[2]);
		bw(ctl, 16'h0004);
		settle(2);
		cmp1("abort_pin", 1'b0, pin);
		rc(st, 16'h0001, "abort_request");
		cmp1("abort_irq", 1'b1, irq);
		rc(acnt, 16'h0100, "abort_reload");
		a_trg <= 1'b0;
		bw(st, 16'h0001);
		// Timer to PWM raises a request
		bw(ctl, 16'h0000);
		bw(acnt, 16'h0003);
		bw(ctl, 16'h0306);
		rc(st, 16'h0001, "pwm_select");
		bw(st, 16'h0001);
		// Stop while high
		bw(ctl, 16'h0307);
		wait_pin(1'b1);
		bw(ctl, 16'h0306);
		settle(2);
		cmp1("pwm_stop_high", 1'b0, pin);
		rc(st, 16'h0001, "pwm_high_request");
		bw(st, 16'h0001);
		// Stop while low
		bw(ctl, 16'h0307);
		wait_pin(1'b1);
		wait_pin(1'b0);
		// End of the high phase raised a request; clear it before stopping
		bw(st, 16'h0001);
		bw(ctl, 16'h0306);
		settle(10);
		cmp1("pwm_stop_low", 1'b0, pin);
		rc(st, 16'h0000, "pwm_low_request");
		results();
	end
endmodule : tmr_core_bench
